//--- rigm_cfg.svh
`ifndef RIGM_CFG_SVH
`define RIGM_CFG_SVH
// Register byte offsets
`define RIGM_OFF_MODE 12'h000
`define RIGM_OFF_IRQ_EN 12'h004
`define RIGM_OFF_POLARITY 12'h008
`define RIGM_OFF_GPIO_DIR 12'h00C
`define RIGM_OFF_GPIO_OUT 12'h010
`define RIGM_OFF_GPIO_IN 12'h014
`define RIGM_OFF_STATUS 12'h018
`define RIGM_OFF_HOST 12'h01C
// Mode register fields
`define RIGM_MODE_CLK6_GPIO 0
`define RIGM_MODE_CLK4_GPIO 1
`define RIGM_MODE_SER2_GPIO 2
`define RIGM_MODE_GP0_OUT 3
`define RIGM_MODE_GP0_IRQ 4
// Status fields
`define RIGM_STAT_PCI 0
`define RIGM_STAT_WIDE 1
`define RIGM_STAT_NMI 2
// Host control fields
`define RIGM_HOST_IRQ 0
`define RIGM_HOST_RDY 1
// Reset values
`define RIGM_MODE_RST 5'h00
`define RIGM_IRQ_EN_RST 4'h0
`define RIGM_POL_RST 4'h0
`define RIGM_DIR_RST 16'h0000
`define RIGM_OUT_RST 16'h0000
// Clock divider counts
`define RIGM_DIV6 3'h6
`define RIGM_DIV4 3'h4
// Width strap pin index
`define RIGM_WIDTH_STRAP_BIT 5
`endif

//--- rigm_clk_div.sv
`timescale 1ns/1ps
module rigm_clk_div (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Divider setting and output
  input wire logic [2:0] ratio,
  output logic clk_level
);
  logic [2:0] cnt_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= 3'h0;
      clk_level <= 1'b0;
    end else if (cnt_reg == ratio - 3'h1) begin
      cnt_reg <= 3'h0;
      clk_level <= 1'b0;
    end else begin
      cnt_reg <= cnt_reg + 3'h1;
      if (cnt_reg == (ratio >> 1) - 3'h1) begin
        clk_level <= 1'b1;
      end
    end
  end
endmodule : rigm_clk_div

//--- rigm_edge_det.sv
`timescale 1ns/1ps
module rigm_edge_det #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Levels, polarity and edge pulses
  input wire logic [W-1:0] level,
  input wire logic [W-1:0] fall_sel,
  output logic [W-1:0] edge_pulse
);
  logic [W-1:0] prev_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_reg <= '0;
      edge_pulse <= '0;
    end else begin
      prev_reg <= level;
      edge_pulse <= (fall_sel & prev_reg & ~level) | (~fall_sel & ~prev_reg & level);
    end
  end
endmodule : rigm_edge_det

//--- rigm_host_model.sv
`timescale 1ns/1ps
module rigm_host_model (
  // Clock and strap level
  input wire logic aclk,
  input wire logic width_strap,
  // Host pins
  output rigm_pkg::rigm_host_ctl_s host_ctl_pins,
  output logic [31:0] host_data_pin_in
);
  import rigm_pkg::*;
  logic [3:0] step_reg = 4'h0;
  // Walks control, address and data selects
  always @(posedge aclk) begin
    step_reg <= (step_reg == 4'hB) ? 4'h0 : step_reg + 4'h1;
  end
  always_comb begin
    host_ctl_pins.host_reg_select_hi = step_reg[3];
    host_ctl_pins.host_reg_select_lo = step_reg[2];
    host_ctl_pins.host_halfword_select = step_reg[0];
    host_ctl_pins.host_rw_select = step_reg[1];
    host_ctl_pins.host_addr_strobe = !step_reg[0];
    host_ctl_pins.host_chip_select = step_reg[0];
    host_ctl_pins.host_data_strobe_a = step_reg[1];
    host_ctl_pins.host_data_strobe_b = !step_reg[1];
    host_data_pin_in = {{6{step_reg}}, 2'h1, width_strap, 1'h0, step_reg};
  end
endmodule : rigm_host_model

//--- rigm_pin_mux.sv
// Behaviour
// RL1: NMI is raised on a rising edge of its input pin only.
// RL2: Shared interrupt pins gpio 7..4 are inputs only after reset.
// RL3: Interrupt-enable bits 7..4 make those pins edge interrupt inputs.
// RL4: Four polarity bits choose each external interrupt's active edge.
// RL5: Gpio 15..9 idle after reset; later bidirectional gpio or PCI signal.
// RL6: PCI enable strap picks host port plus gpio 15..9, or PCI.
// RL7: Gpio 3 is input only after reset, later bidirectional.
// RL8: Gpio 0 input by default; output or general interrupt-out later.
// RL9: Divide-by-six pin drives core clock over six unless set to gpio 2.
// RL10: Divide-by-four pin drives core clock over four unless set to gpio 1.
// RL11: Serial-port-two clock pin is input by default, else gpio 8.
// RL12: Host interrupt pin is output in host mode, PCI frame otherwise.
// RL13: Host drives two register-select inputs choosing control, address, data.
// RL14: Host drives half-word select marking first or second half-word.
// RL15: Host drives read/write select; PCI mode carries command/byte enable 2.
// RL16: Host drives strobes and chip select; PCI carries parity and errors.
// RL17: Host ready pin is driven in host mode, PCI initiator ready otherwise.
// RL18: Data pins are host data when strap is 0, PCI bus when 1.
// RL19: Data pin 5 at reset picks 16-bit port (0) or 32-bit (1).
// RL20: Straps are captured once at reset release and held until reset.
`timescale 1ns/1ps
`include "rigm_cfg.svh"
module rigm_pin_mux (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Straps
  input wire logic pci_enable_strap,
  // Nonmaskable interrupt
  input wire logic nmi_in,
  output logic nmi_pulse,
  // Gpio pins (output enable low while driving)
  input wire logic [15:0] gpio_pin_in,
  output logic [15:0] gpio_pin_out,
  output logic [15:0] gpio_pin_oe_n,
  // Core-side events and clocks
  output logic [3:0] external_irq_in,
  output logic serial2_ext_clk_in,
  output logic gp_irq_out,
  // Host port control pins as seen by the core
  input wire rigm_pkg::rigm_host_ctl_s host_ctl_pins,
  output rigm_pkg::rigm_host_ctl_s host_ctl,
  output logic host_ctl_valid,
  // Host interrupt / ready pins
  output logic host_irq_out,
  output logic host_irq_oe_n,
  output logic host_ready_out,
  output logic host_ready_oe_n,
  // Shared data pins
  input wire logic [31:0] host_data_pin_in,
  output logic [31:0] host_data_oe_mask_n,
  // Port role seen by core logic
  output rigm_pkg::rigm_port_e port_role
);
  import rigm_pkg::*;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        old[i*8 +: 8] = nv[i*8 +: 8];
      end
    end
    return old;
  endfunction : merge

  logic [4:0] mode_reg;
  logic [3:0] irq_en_reg;
  logic [3:0] polarity_reg;
  logic [15:0] dir_reg;
  logic [15:0] out_reg;
  logic [1:0] host_reg;
  logic strap_done_reg;
  logic pci_reg;
  logic wide_reg;
  logic nmi_flag_reg;
  logic aw_held_reg;
  logic w_held_reg;
  rigm_wr_s wr_reg;
  logic clk6;
  logic clk4;
  logic [3:0] ext_edges;
  logic [0:0] nmi_edge;
  logic [31:0] wr_next;
  logic [31:0] rd_next;
  logic wr_fire;
  logic aw_held_next;
  logic w_held_next;
  logic bvalid_next;

  // Straps caught at first clocked cycle after release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_done_reg <= 1'b0;
      pci_reg <= 1'b0;
      wide_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_done_reg <= 1'b1;
      pci_reg <= pci_enable_strap; // RL6 RL20
      wide_reg <= host_data_pin_in[`RIGM_WIDTH_STRAP_BIT]; // RL19 RL20
    end
  end

  rigm_clk_div u_div6 (.aclk(aclk), .aresetn(aresetn), .ratio(`RIGM_DIV6), .clk_level(clk6));
  rigm_clk_div u_div4 (.aclk(aclk), .aresetn(aresetn), .ratio(`RIGM_DIV4), .clk_level(clk4));

  rigm_edge_det #(.W(4)) u_ext (
    .aclk(aclk), .aresetn(aresetn), .level(gpio_pin_in[7:4]),
    .fall_sel(polarity_reg), .edge_pulse(ext_edges) // RL4
  );
  rigm_edge_det #(.W(1)) u_nmi (
    .aclk(aclk), .aresetn(aresetn), .level(nmi_in), .fall_sel(1'b0),
    .edge_pulse(nmi_edge) // RL1
  );

  // AXI write channel capture
  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
  // Next holds, so the readies can come from flops
  always_comb begin
    aw_held_next = aw_held_reg || (s_axi_awvalid && s_axi_awready);
    w_held_next = w_held_reg || (s_axi_wvalid && s_axi_wready);
    bvalid_next = s_axi_bvalid && !s_axi_bready;
    if (wr_fire) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      wr_reg <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      s_axi_bvalid <= bvalid_next;
      s_axi_awready <= !aw_held_next && !bvalid_next;
      s_axi_wready <= !w_held_next && !bvalid_next;
      if (s_axi_awvalid && s_axi_awready) begin
        wr_reg.addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wr_reg.data <= s_axi_wdata;
        wr_reg.strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bresp <= (wr_reg.addr[11:2] > `RIGM_OFF_HOST >> 2) ? 2'b10 : 2'b00;
      end
    end
  end

  // Register writes
  always_comb begin
    wr_next = 32'h0000_0000;
    unique case (wr_reg.addr & 12'hFFC)
      `RIGM_OFF_MODE: wr_next = merge({27'h0, mode_reg}, wr_reg.data, wr_reg.strb);
      `RIGM_OFF_IRQ_EN: wr_next = merge({24'h0, irq_en_reg, 4'h0}, wr_reg.data, wr_reg.strb);
      `RIGM_OFF_POLARITY: wr_next = merge({28'h0, polarity_reg}, wr_reg.data, wr_reg.strb);
      `RIGM_OFF_GPIO_DIR: wr_next = merge({16'h0, dir_reg}, wr_reg.data, wr_reg.strb);
      `RIGM_OFF_GPIO_OUT: wr_next = merge({16'h0, out_reg}, wr_reg.data, wr_reg.strb);
      `RIGM_OFF_HOST: wr_next = merge({30'h0, host_reg}, wr_reg.data, wr_reg.strb);
      default: wr_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= `RIGM_MODE_RST; // RL8 RL9 RL10 RL11
      irq_en_reg <= `RIGM_IRQ_EN_RST; // RL2
      polarity_reg <= `RIGM_POL_RST;
      dir_reg <= `RIGM_DIR_RST; // RL2 RL5 RL7
      out_reg <= `RIGM_OUT_RST;
      host_reg <= 2'b00;
    end else if (wr_fire) begin
      unique case (wr_reg.addr & 12'hFFC)
        `RIGM_OFF_MODE: mode_reg <= wr_next[4:0];
        `RIGM_OFF_IRQ_EN: irq_en_reg <= wr_next[7:4]; // RL3
        `RIGM_OFF_POLARITY: polarity_reg <= wr_next[3:0]; // RL4
        `RIGM_OFF_GPIO_DIR: dir_reg <= wr_next[15:0];
        `RIGM_OFF_GPIO_OUT: out_reg <= wr_next[15:0];
        `RIGM_OFF_HOST: host_reg <= wr_next[1:0];
        default: ;
      endcase
    end
  end

  // Sticky NMI status, set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nmi_flag_reg <= 1'b0;
    end else if (nmi_edge[0]) begin
      nmi_flag_reg <= 1'b1; // RL1
    end else if (wr_fire && (wr_reg.addr & 12'hFFC) == `RIGM_OFF_STATUS &&
                 wr_reg.strb[0] && wr_reg.data[`RIGM_STAT_NMI]) begin
      nmi_flag_reg <= 1'b0;
    end
  end

  // AXI read channel
  always_comb begin
    rd_next = 32'h0000_0000;
    unique case (s_axi_araddr & 12'hFFC)
      `RIGM_OFF_MODE: rd_next = {27'h0, mode_reg};
      `RIGM_OFF_IRQ_EN: rd_next = {24'h0, irq_en_reg, 4'h0};
      `RIGM_OFF_POLARITY: rd_next = {28'h0, polarity_reg};
      `RIGM_OFF_GPIO_DIR: rd_next = {16'h0, dir_reg};
      `RIGM_OFF_GPIO_OUT: rd_next = {16'h0, out_reg};
      `RIGM_OFF_GPIO_IN: rd_next = {16'h0, gpio_pin_in};
      `RIGM_OFF_STATUS: rd_next = {29'h0, nmi_flag_reg, wide_reg, pci_reg};
      `RIGM_OFF_HOST: rd_next = {30'h0, host_reg};
      default: rd_next = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
      s_axi_arready <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_next;
      s_axi_rresp <= (s_axi_araddr[11:2] > `RIGM_OFF_HOST >> 2) ? 2'b10 : 2'b00;
      s_axi_arready <= 1'b0;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end else begin
      s_axi_arready <= !s_axi_rvalid;
    end
  end

  // Pin function drive, registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gpio_pin_out <= 16'h0000;
      gpio_pin_oe_n <= 16'hFFFF;
      external_irq_in <= 4'h0;
      nmi_pulse <= 1'b0;
      serial2_ext_clk_in <= 1'b0;
      gp_irq_out <= 1'b0;
    end else begin
      nmi_pulse <= nmi_edge[0]; // RL1
      external_irq_in <= ext_edges & irq_en_reg; // RL3
      gpio_pin_out <= out_reg;
      gpio_pin_oe_n <= ~dir_reg;
      gpio_pin_oe_n[7:4] <= 4'hF; // RL2
      gpio_pin_oe_n[15:9] <= pci_reg ? 7'h7F : ~dir_reg[15:9]; // RL5 RL6
      gpio_pin_oe_n[3] <= ~dir_reg[3]; // RL7
      gpio_pin_oe_n[0] <= ~(mode_reg[`RIGM_MODE_GP0_OUT] | mode_reg[`RIGM_MODE_GP0_IRQ]); // RL8
      gpio_pin_out[0] <= mode_reg[`RIGM_MODE_GP0_IRQ] ? host_reg[`RIGM_HOST_IRQ] : out_reg[0];
      gp_irq_out <= mode_reg[`RIGM_MODE_GP0_IRQ] & host_reg[`RIGM_HOST_IRQ]; // RL8
      if (!mode_reg[`RIGM_MODE_CLK6_GPIO]) begin
        gpio_pin_out[2] <= clk6; // RL9
        gpio_pin_oe_n[2] <= 1'b0;
      end
      if (!mode_reg[`RIGM_MODE_CLK4_GPIO]) begin
        gpio_pin_out[1] <= clk4; // RL10
        gpio_pin_oe_n[1] <= 1'b0;
      end
      if (!mode_reg[`RIGM_MODE_SER2_GPIO]) begin
        gpio_pin_oe_n[8] <= 1'b1; // RL11
        serial2_ext_clk_in <= gpio_pin_in[8];
      end else begin
        serial2_ext_clk_in <= 1'b0;
      end
    end
  end

  // Host port pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      host_irq_out <= 1'b0;
      host_irq_oe_n <= 1'b1;
      host_ready_out <= 1'b0;
      host_ready_oe_n <= 1'b1;
      host_ctl <= '0;
      host_ctl_valid <= 1'b0;
      host_data_oe_mask_n <= 32'hFFFF_FFFF;
      port_role <= RIGM_PORT_HOST16;
    end else begin
      host_irq_out <= host_reg[`RIGM_HOST_IRQ];
      // Stay released until the straps are known
      host_irq_oe_n <= pci_reg || !strap_done_reg; // RL12
      host_ready_out <= host_reg[`RIGM_HOST_RDY];
      host_ready_oe_n <= pci_reg || !strap_done_reg; // RL17
      host_ctl <= host_ctl_pins; // RL13 RL14 RL15 RL16
      host_ctl_valid <= strap_done_reg && !pci_reg;
      // Upper half held released in 16-bit host mode
      host_data_oe_mask_n <= (pci_reg || wide_reg) ? 32'h0000_0000 : 32'hFFFF_0000; // RL18 RL19
      port_role <= pci_reg ? RIGM_PORT_PCI : (wide_reg ? RIGM_PORT_HOST32 : RIGM_PORT_HOST16);
    end
  end
endmodule : rigm_pin_mux

//--- rigm_pin_mux_props.sv
`timescale 1ns/1ps
module rigm_pin_mux_props (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Watched pins
  input wire logic nmi_in,
  input wire logic nmi_pulse,
  input wire logic [15:0] gpio_pin_in,
  input wire logic [15:0] gpio_pin_out,
  input wire logic [15:0] gpio_pin_oe_n,
  input wire logic [3:0] external_irq_in,
  input wire logic serial2_ext_clk_in,
  input wire rigm_pkg::rigm_host_ctl_s host_ctl_pins,
  input wire rigm_pkg::rigm_host_ctl_s host_ctl,
  input wire logic host_ctl_valid,
  input wire logic host_irq_oe_n,
  input wire logic host_ready_oe_n,
  input wire logic [31:0] host_data_oe_mask_n,
  input wire rigm_pkg::rigm_port_e port_role
);
  import rigm_pkg::*;
  logic [1:0] cyc_reg;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Cycles since reset release, saturating
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cyc_reg <= 2'h0;
    end else if (cyc_reg != 2'h3) begin
      cyc_reg <= cyc_reg + 2'h1;
    end
  end
  a_nmi_rise: assert property ($rose(nmi_in) |-> ##[1:4] nmi_pulse)
    else $error("nmi edge missed");
  a_nmi_single: assert property (nmi_pulse |=> !nmi_pulse)
    else $error("nmi pulse too long");
  a_irq_pins_undriven: assert property (&gpio_pin_oe_n[7:4])
    else $error("irq pin driven");
  a_irq_pulse_short: assert property (external_irq_in != 4'h0 |=> external_irq_in == 4'h0)
    else $error("irq pulse too long");
  a_pci_release: assert property (port_role == RIGM_PORT_PCI |->
    &gpio_pin_oe_n[15:9] && host_irq_oe_n && host_ready_oe_n)
    else $error("pin driven in pci mode");
  a_host_pins_driven: assert property (host_ctl_valid && $past(host_ctl_valid) |->
    !host_irq_oe_n && !host_ready_oe_n)
    else $error("host outputs released");
  a_host_ctl_copy: assert property (host_ctl_valid && $past(host_ctl_valid) |->
    host_ctl == $past(host_ctl_pins))
    else $error("host control not passed");
  a_role_hold: assert property (cyc_reg == 2'h3 |-> $stable(port_role))
    else $error("port role changed");
  a_width_mask: assert property (cyc_reg == 2'h3 && port_role != RIGM_PORT_PCI |->
    host_data_oe_mask_n == ((port_role == RIGM_PORT_HOST16) ? 32'hFFFF_0000 : 32'h0))
    else $error("data mask wrong");
  a_div6_shape: assert property ($rose(gpio_pin_out[2]) && !gpio_pin_oe_n[2] |->
    (gpio_pin_out[2] || gpio_pin_oe_n[2]) [*3] ##1 (!gpio_pin_out[2] || gpio_pin_oe_n[2]) [*3])
    else $error("div6 shape wrong");
  a_div4_shape: assert property ($rose(gpio_pin_out[1]) && !gpio_pin_oe_n[1] |->
    (gpio_pin_out[1] || gpio_pin_oe_n[1]) [*2] ##1 (!gpio_pin_out[1] || gpio_pin_oe_n[1]) [*2])
    else $error("div4 shape wrong");
  a_serial_clk_copy: assert property (serial2_ext_clk_in |-> $past(gpio_pin_in[8]))
    else $error("serial clock without pin");
endmodule : rigm_pin_mux_props

bind rigm_pin_mux rigm_pin_mux_props u_rigm_pin_mux_props (
  .aclk, .aresetn, .nmi_in, .nmi_pulse, .gpio_pin_in, .gpio_pin_out, .gpio_pin_oe_n,
  .external_irq_in, .serial2_ext_clk_in, .host_ctl_pins, .host_ctl, .host_ctl_valid,
  .host_irq_oe_n, .host_ready_oe_n, .host_data_oe_mask_n, .port_role
);

//--- rigm_pin_mux_test.sv
`timescale 1ns/1ps
module rigm_pin_mux_test;
  import rigm_pkg::*;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, host_data_pin_in, host_data_oe_mask_n, rv;
  logic [3:0] s_axi_wstrb = 4'hF, external_irq_in;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, pci_enable_strap = 1'h0;
  logic wide_strap = 1'h0, nmi_in = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic nmi_pulse, serial2_ext_clk_in, gp_irq_out, host_ctl_valid;
  logic host_irq_out, host_irq_oe_n, host_ready_out, host_ready_oe_n;
  logic [15:0] gpio_pin_in = 16'h0, gpio_pin_out, gpio_pin_oe_n;
  logic [2:1] clk_prev = 2'h0;
  rigm_host_ctl_s host_ctl_pins, host_ctl;
  rigm_port_e port_role;
  int fail_count = 0, num_checks = 0, nmi_cnt = 0, div6_cnt = 0, div4_cnt = 0;
  int irq_cnt [4] = '{0, 0, 0, 0};
  always #50 aclk = ~aclk;
  rigm_pin_mux u_rigm_pin_mux (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .pci_enable_strap, .nmi_in, .nmi_pulse, .gpio_pin_in, .gpio_pin_out, .gpio_pin_oe_n,
    .external_irq_in, .serial2_ext_clk_in, .gp_irq_out, .host_ctl_pins, .host_ctl,
    .host_ctl_valid, .host_irq_out, .host_irq_oe_n, .host_ready_out, .host_ready_oe_n,
    .host_data_pin_in, .host_data_oe_mask_n, .port_role
  );
  rigm_host_model u_rigm_host_model (
    .aclk, .width_strap(wide_strap), .host_ctl_pins, .host_data_pin_in
  );
  // Event counters
  always @(posedge aclk) begin
    if (nmi_pulse === 1'h1) nmi_cnt <= nmi_cnt + 1;
    for (int i = 0; i < 4; i++) if (external_irq_in[i] === 1'h1) irq_cnt[i] <= irq_cnt[i] + 1;
    if (gpio_pin_out[2] === 1'h1 && !clk_prev[2]) div6_cnt <= div6_cnt + 1;
    if (gpio_pin_out[1] === 1'h1 && !clk_prev[1]) div4_cnt <= div4_cnt + 1;
    clk_prev <= gpio_pin_out[2:1];
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    tb = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!tb) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      rr = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
    end
    s_axi_bready <= 1'h0;
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    logic ta, tr;
    tr = 1'h0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!tr) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      rv = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'h0;
    end
    s_axi_rready <= 1'h0;
    @(posedge aclk);
  endtask : rd
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    rd(a);
    chk(rv, e);
  endtask : rchk
  task automatic t_straps();
    for (int i = 2; i >= 0; i--) begin
      pci_enable_strap <= i[1];
      wide_strap <= i[0];
      aresetn <= 1'h0;
      tick(2);
      aresetn <= 1'h1;
      tick(3);
      pci_enable_strap <= !i[1];
      wide_strap <= !i[0];
      tick(4);
      chk(port_role, i == 2 ? RIGM_PORT_PCI : i == 1 ? RIGM_PORT_HOST32 : RIGM_PORT_HOST16);
      rchk(12'h18, {30'h0, i[0], i[1]});
      if (i < 2) chk(host_data_oe_mask_n, i == 0 ? 32'hFFFF_0000 : 32'h0);
      if (i == 2) chk({gpio_pin_oe_n[15:9], host_irq_oe_n, host_ready_oe_n}, 9'h1FF);
    end
  endtask : t_straps
  task automatic t_defaults();
    for (int a = 0; a < 16; a += 4) rchk(a[11:0], 32'h0);
    chk(gpio_pin_oe_n, 16'hFFF9);
    chk({host_irq_oe_n, host_ready_oe_n, host_ctl_valid}, 3'h1);
  endtask : t_defaults
  task automatic t_clocks();
    int c6, c4;
    c6 = div6_cnt;
    c4 = div4_cnt;
    gpio_pin_in[8] <= 1'h1;
    tick(60);
    chk(div6_cnt - c6, 10);
    chk(div4_cnt - c4, 15);
    chk(serial2_ext_clk_in, 1'h1);
    wr(12'h0, 32'h7);
    tick(3);
    chk({gpio_pin_oe_n[2:1], serial2_ext_clk_in}, 3'h6);
  endtask : t_clocks
  task automatic t_nmi();
    int n;
    n = nmi_cnt;
    nmi_in <= 1'h1;
    tick(10);
    chk(nmi_cnt - n, 1);
    rchk(12'h18, 32'h4);
    nmi_in <= 1'h0;
    wr(12'h18, 32'h4);
    rchk(12'h18, 32'h0);
    chk(nmi_cnt - n, 1);
  endtask : t_nmi
  task automatic t_irq();
    int c [4];
    wr(12'h4, 32'hD0);
    wr(12'h8, 32'h4);
    c = irq_cnt;
    gpio_pin_in[7:4] <= 4'hF;
    tick(6);
    for (int i = 0; i < 4; i++) chk(irq_cnt[i] - c[i], i == 0 || i == 3);
    gpio_pin_in[7:4] <= 4'h0;
    tick(6);
    for (int i = 0; i < 4; i++) chk(irq_cnt[i] - c[i], i != 1);
  endtask : t_irq
  task automatic t_gpio();
    wr(12'hC, 32'hFEF8);
    wr(12'h10, 32'hAA08);
    tick(2);
    chk(gpio_pin_oe_n, 16'h01F7);
    chk({gpio_pin_out[15:9], gpio_pin_out[3]}, 8'hAB);
    wr(12'h0, 32'h1F);
    wr(12'h1C, 32'h3);
    tick(2);
    chk({gp_irq_out, gpio_pin_oe_n[0], host_irq_out, host_ready_out}, 4'hB);
    rd(12'h20);
    chk(rr, 2'h2);
    chk(rv, 32'h0000_0000);
    wr(12'h20, 32'hFFFF_FFFF);
    chk(rr, 2'h2);
  endtask : t_gpio
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    t_straps();
    t_defaults();
    t_clocks();
    t_nmi();
    t_irq();
    t_gpio();
    tally_and_finish();
  end
  initial begin
    #(3000 * 100);
    fail_count++;
    tally_and_finish();
  end
endmodule : rigm_pin_mux_test

//--- rigm_pkg.sv
package rigm_pkg;
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } rigm_wr_s;
  typedef struct packed {
    logic host_reg_select_hi;
    logic host_reg_select_lo;
    logic host_halfword_select;
    logic host_rw_select;
    logic host_addr_strobe;
    logic host_chip_select;
    logic host_data_strobe_a;
    logic host_data_strobe_b;
  } rigm_host_ctl_s;
  typedef enum logic [1:0] {
    RIGM_PORT_HOST16,
    RIGM_PORT_HOST32,
    RIGM_PORT_PCI
  } rigm_port_e;
endpackage : rigm_pkg
